// *** apt_defs.svh ***
`ifndef APT_DEFS_SVH
`define APT_DEFS_SVH

// Register byte offsets
`define APT_OFS_CTRL      12'h300
`define APT_OFS_CHAN      12'h304
`define APT_OFS_INFO      12'h308
`define APT_OFS_MVAL      12'h328
`define APT_OFS_NVAL      12'h32c
`define APT_OFS_EXT_LO    12'h330
`define APT_OFS_EXT_HI    12'h350

// Field positions and widths
`define APT_CTRL_EN_BIT   0
`define APT_CHAN_W        3
`define APT_MN_W          24

// Reset values
`define APT_RST_CTRL      1'h0
`define APT_RST_CHAN      3'h0

// Packet sizes in 32-bit words
`define APT_INFO_WORDS    8
`define APT_EXT_WORDS     9

// Audio timing figures
`define APT_N_DEFAULT     32768
`define APT_M_SCALE       24'h000200

`endif

// *** apt_pkg.sv ***
package apt_pkg;

  typedef enum logic [2:0] {
    APT_IDLE = 3'h0,
    APT_SAMP = 3'h1,
    APT_INFO = 3'h3,
    APT_EXT  = 3'h2
  } apt_state_t;

  typedef enum logic [1:0] {
    APT_KIND_SAMPLE = 2'h0,
    APT_KIND_INFO   = 2'h1,
    APT_KIND_EXT    = 2'h2
  } apt_kind_t;

  typedef struct packed {
    apt_kind_t   kind;
    logic        sof;
    logic        eof;
    logic [31:0] data;
  } apt_word_t;

endpackage : apt_pkg

// *** apt_audio_tx.sv ***
// What this block does
// - Audio packets start only while the enable bit is set; a packet already started runs to its end.
// - Three-bit channel count sets how many samples each audio packet gathers.
// - First info word holds header bytes 0 to 3, low lane first.
// - Data bytes renumbered from zero; word two holds bytes 3 down to 0.
// - A 24-bit M value is computed from synchronous clocks and readable.
// - A 24-bit N value is kept for synchronous clocks and readable.
// - One 32-byte extension packet is stored at a time.
// - First extension word holds header bytes 0 to 3; word two data 31..28.

`include "apt_defs.svh"

module apt_fifo #(
  parameter int WIDTH = 32,
  parameter int DEPTH = 16
) (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic [WIDTH-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_ptr_reg;
  logic [AW:0]      rd_ptr_reg;

  wire push  = in_valid & in_ready;
  wire pop   = out_valid & out_ready;
  wire empty = wr_ptr_reg == rd_ptr_reg;
  wire full  = (wr_ptr_reg[AW] != rd_ptr_reg[AW]) &&
               (wr_ptr_reg[AW-1:0] == rd_ptr_reg[AW-1:0]);

  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = mem[rd_ptr_reg[AW-1:0]];

  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wr_ptr_reg[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
    end else begin
      wr_ptr_reg <= wr_ptr_reg + (AW+1)'(push);
      rd_ptr_reg <= rd_ptr_reg + (AW+1)'(pop);
    end
  end
endmodule : apt_fifo

module apt_audio_tx #(
  parameter int N_WINDOW   = `APT_N_DEFAULT,
  parameter int FIFO_DEPTH = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              lnk_clk_in,
  input  wire logic              aud_fs_in,
  input  wire logic              aud_in_valid,
  output logic                   aud_in_ready,
  input  wire logic [31:0]       aud_in_data,
  output logic                   pk_valid,
  input  wire logic              pk_ready,
  output apt_pkg::apt_word_t     pk_word
);
  import apt_pkg::*;

  function automatic logic [3:0] samples_per_pkt(input logic [2:0] cnt);
    samples_per_pkt = (cnt == 3'h0) ? 4'h1 : {1'b0, cnt};
  endfunction : samples_per_pkt

  function automatic logic [3:0] wrap_inc(input logic [3:0] ptr, input logic [3:0] last);
    wrap_inc = (ptr == last) ? 4'h0 : ptr + 4'h1;
  endfunction : wrap_inc

  // Pin synchronisers and edge detection
  logic [2:0] lnk_sync_reg;
  logic [2:0] fs_sync_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lnk_sync_reg <= 3'h0;
      fs_sync_reg  <= 3'h0;
    end else begin
      lnk_sync_reg <= {lnk_sync_reg[1:0], lnk_clk_in};
      fs_sync_reg  <= {fs_sync_reg[1:0], aud_fs_in};
    end
  end

  wire link_tick = lnk_sync_reg[1] & ~lnk_sync_reg[2];
  wire fs_tick   = fs_sync_reg[1] & ~fs_sync_reg[2];

  // APB decode
  wire setup_ph = psel & ~penable;
  wire access   = psel & penable;
  wire wr_acc   = access & pwrite;
  wire hit_ctrl = paddr == `APT_OFS_CTRL;
  wire hit_chan = paddr == `APT_OFS_CHAN;
  wire hit_info = paddr == `APT_OFS_INFO;
  wire hit_mval = paddr == `APT_OFS_MVAL;
  wire hit_nval = paddr == `APT_OFS_NVAL;
  wire hit_ext  = (paddr >= `APT_OFS_EXT_LO) && (paddr <= `APT_OFS_EXT_HI) &&
                  (paddr[1:0] == 2'h0);
  wire mapped   = hit_ctrl | hit_chan | hit_info | hit_mval | hit_nval | hit_ext;

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Control registers
  logic                    en_reg;
  logic [`APT_CHAN_W-1:0]  chan_reg;
  logic [31:0]             prdata_reg;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg   <= `APT_RST_CTRL;
      chan_reg <= `APT_RST_CHAN;
    end else begin
      if (wr_acc && hit_ctrl) begin
        en_reg <= pwdata[`APT_CTRL_EN_BIT];
      end
      if (wr_acc && hit_chan) begin
        chan_reg <= pwdata[`APT_CHAN_W-1:0];
      end
    end
  end

  // Keyhole packet stores
  logic [31:0] info_mem [`APT_INFO_WORDS];
  logic [31:0] ext_mem  [`APT_EXT_WORDS];
  logic [3:0]  info_ptr_reg;
  logic [3:0]  ext_ptr_reg;
  logic        info_pend_reg;
  logic        ext_pend_reg;
  logic        info_done;
  logic        ext_done;

  localparam logic [3:0] INFO_LAST = 4'(`APT_INFO_WORDS - 1);
  localparam logic [3:0] EXT_LAST  = 4'(`APT_EXT_WORDS - 1);

  wire info_wr   = wr_acc & hit_info;
  wire ext_wr    = wr_acc & hit_ext;
  wire info_full = info_wr & (info_ptr_reg == INFO_LAST);
  wire ext_full  = ext_wr & (ext_ptr_reg == EXT_LAST);

  always_ff @(posedge pclk) begin
    if (info_wr) begin
      info_mem[info_ptr_reg[2:0]] <= pwdata;
    end
    if (ext_wr) begin
      ext_mem[ext_ptr_reg] <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      info_ptr_reg  <= 4'h0;
      ext_ptr_reg   <= 4'h0;
      info_pend_reg <= 1'b0;
      ext_pend_reg  <= 1'b0;
    end else begin
      if (info_wr) begin
        info_ptr_reg <= wrap_inc(info_ptr_reg, INFO_LAST);
      end
      if (ext_wr) begin
        ext_ptr_reg <= wrap_inc(ext_ptr_reg, EXT_LAST);
      end
      if (info_full) begin
        info_pend_reg <= 1'b1;
      end else if (info_done) begin
        info_pend_reg <= 1'b0;
      end
      if (ext_full) begin
        ext_pend_reg <= 1'b1;
      end else if (ext_done) begin
        ext_pend_reg <= 1'b0;
      end
    end
  end

  // Audio M and N values
  localparam logic [`APT_MN_W-1:0] N_VALUE = `APT_MN_W'(N_WINDOW);
  localparam logic [`APT_MN_W-1:0] N_LAST  = `APT_MN_W'(N_WINDOW - 1);

  logic [`APT_MN_W-1:0] n_cnt_reg;
  logic [`APT_MN_W-1:0] m_acc_reg;
  logic [`APT_MN_W-1:0] m_val_reg;

  wire                  win_end = link_tick & (n_cnt_reg == N_LAST);
  wire [`APT_MN_W-1:0]  m_add   = fs_tick ? `APT_M_SCALE : '0;
  wire [`APT_MN_W-1:0]  m_sum   = m_acc_reg + m_add;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      n_cnt_reg <= '0;
      m_acc_reg <= '0;
      m_val_reg <= '0;
    end else begin
      if (link_tick) begin
        n_cnt_reg <= win_end ? '0 : n_cnt_reg + `APT_MN_W'(1);
      end
      m_acc_reg <= win_end ? '0 : m_sum;
      if (win_end) begin
        m_val_reg <= m_sum;
      end
    end
  end

  // Read data, captured in the setup phase
  logic [31:0] rd_mux;

  always_comb begin
    rd_mux = 32'h0;
    if (hit_ctrl) begin
      rd_mux = {31'h0, en_reg};
    end else if (hit_chan) begin
      rd_mux = {29'h0, chan_reg};
    end else if (hit_mval) begin
      rd_mux = {8'h0, m_val_reg};
    end else if (hit_nval) begin
      rd_mux = {8'h0, N_VALUE};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0;
    end else if (setup_ph && !pwrite) begin
      prdata_reg <= rd_mux;
    end
  end

  assign prdata = prdata_reg;

  // Sample buffer
  logic        fifo_valid;
  logic        fifo_pop;
  logic [31:0] fifo_data;

  apt_fifo #(
    .WIDTH (32),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .pclk      (pclk),
    .presetn   (presetn),
    .in_valid  (aud_in_valid),
    .in_ready  (aud_in_ready),
    .in_data   (aud_in_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_pop),
    .out_data  (fifo_data)
  );

  // Packet sequencer, paced by link clock edges
  apt_state_t  state_reg;
  apt_state_t  state_next;
  logic [3:0]  idx_reg;
  logic [3:0]  idx_next;
  apt_word_t   out_reg;
  apt_word_t   word_next;
  logic        out_valid_reg;
  logic        load;

  wire       xfer     = out_valid_reg & pk_ready;
  wire       can_load = link_tick & (~out_valid_reg | xfer);
  wire [3:0] samp_n   = samples_per_pkt(chan_reg);

  always_comb begin
    state_next = state_reg;
    idx_next   = idx_reg;
    word_next  = out_reg;
    load       = 1'b0;
    fifo_pop   = 1'b0;
    info_done  = 1'b0;
    ext_done   = 1'b0;
    case (state_reg)
      APT_IDLE: begin
        if (en_reg && can_load) begin
          idx_next = 4'h0;
          if (ext_pend_reg) begin
            state_next = APT_EXT;
          end else if (info_pend_reg) begin
            state_next = APT_INFO;
          end else if (fifo_valid) begin
            load       = 1'b1;
            word_next  = '{APT_KIND_SAMPLE, 1'b1, 1'b0, {29'h0, chan_reg}};
            state_next = APT_SAMP;
          end
        end
      end
      APT_SAMP: begin
        if (can_load && fifo_valid) begin
          load      = 1'b1;
          fifo_pop  = 1'b1;
          word_next = '{APT_KIND_SAMPLE, 1'b0, idx_reg == samp_n - 4'h1, fifo_data};
          idx_next  = idx_reg + 4'h1;
          if (idx_reg == samp_n - 4'h1) begin
            state_next = APT_IDLE;
          end
        end
      end
      APT_INFO: begin
        if (can_load) begin
          load      = 1'b1;
          word_next = '{APT_KIND_INFO, idx_reg == 4'h0, idx_reg == INFO_LAST,
                        info_mem[idx_reg[2:0]]};
          idx_next  = idx_reg + 4'h1;
          if (idx_reg == INFO_LAST) begin
            info_done  = 1'b1;
            state_next = APT_IDLE;
          end
        end
      end
      APT_EXT: begin
        if (can_load) begin
          load      = 1'b1;
          word_next = '{APT_KIND_EXT, idx_reg == 4'h0, idx_reg == EXT_LAST,
                        ext_mem[idx_reg]};
          idx_next  = idx_reg + 4'h1;
          if (idx_reg == EXT_LAST) begin
            ext_done   = 1'b1;
            state_next = APT_IDLE;
          end
        end
      end
      default: begin
        state_next = APT_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg     <= APT_IDLE;
      idx_reg       <= 4'h0;
      out_reg       <= '0;
      out_valid_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      idx_reg   <= idx_next;
      if (load) begin
        out_reg <= word_next;
      end
      if (load) begin
        out_valid_reg <= 1'b1;
      end else if (xfer) begin
        out_valid_reg <= 1'b0;
      end
    end
  end

  assign pk_valid = out_valid_reg;
  assign pk_word  = out_reg;
endmodule : apt_audio_tx

// *** apt_audio_tx_properties.sv ***
module apt_audio_tx_properties #(
  parameter int N_WINDOW = 32768
) (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [11:0]        paddr,
  input wire logic [31:0]        pwdata,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               pk_valid,
  input wire logic               pk_ready,
  input wire apt_pkg::apt_word_t pk_word
);
  timeunit 1ns;
  timeprecision 1ns;
  import apt_pkg::*;
  logic       en_reg;
  logic [2:0] chan_reg;
  wire ext_hit = paddr >= 12'h330 && paddr <= 12'h350 && paddr[1:0] == 2'h0;
  wire mapped  = paddr inside {12'h300, 12'h304, 12'h308, 12'h328, 12'h32c} || ext_hit;
  wire acc_wr  = psel && penable && pwrite && pready;
  wire acc_rd  = psel && penable && !pwrite;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      en_reg   <= 1'b0;
      chan_reg <= 3'h0;
    end else if (acc_wr) begin
      if (paddr == 12'h300) en_reg <= pwdata[0];
      if (paddr == 12'h304) chan_reg <= pwdata[2:0];
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_ready_high: assert property (psel && penable |-> pready)
    else $error("pready low in access phase");
  chk_slverr_map: assert property (pslverr == (psel && penable && !mapped))
    else $error("pslverr does not match decode");
  chk_rst_idle: assert property ($rose(presetn) |-> !pk_valid && pk_word == '0)
    else $error("output busy after reset");
  chk_word_hold: assert property (pk_valid && !pk_ready |=> pk_valid && $stable(pk_word))
    else $error("output word dropped before taken");
  chk_start_enabled: assert property (pk_valid && pk_word.sof && !$past(pk_valid) |-> $past(en_reg))
    else $error("packet started while disabled");
  chk_chan_header: assert property (pk_valid && pk_word.sof && pk_word.kind == APT_KIND_SAMPLE
    |-> pk_word.data[2:0] == chan_reg)
    else $error("header channel count wrong");
  chk_n_read: assert property (acc_rd && paddr == 12'h32c |-> prdata == 32'(N_WINDOW))
    else $error("N value read wrong");
  chk_m_form: assert property (acc_rd && paddr == 12'h328 |-> prdata[31:24] == 8'h00)
    else $error("M value wider than 24 bits");
  chk_port_read: assert property (acc_rd && (paddr == 12'h308 || ext_hit) |-> prdata == 32'h0)
    else $error("write-only port read not zero");
endmodule : apt_audio_tx_properties

bind apt_audio_tx apt_audio_tx_properties #(.N_WINDOW(N_WINDOW)) apt_audio_tx_properties_inst (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .pk_valid(pk_valid), .pk_ready(pk_ready), .pk_word(pk_word));

// *** apt_sink_model.sv ***
module apt_sink_model (
  input wire logic               pclk,
  input wire logic               presetn,
  input wire logic               slow,
  input wire logic               pk_valid,
  output logic                   pk_ready,
  input wire apt_pkg::apt_word_t pk_word
);
  timeunit 1ns;
  timeprecision 1ns;
  import apt_pkg::*;
  apt_word_t got[$];
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) pk_ready <= 1'b0;
    else begin
      if (pk_valid && pk_ready) got.push_back(pk_word);
      pk_ready <= slow ? 1'($urandom_range(1)) : 1'b1;
    end
  end
endmodule : apt_sink_model

// *** tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import apt_pkg::*;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic lnk_clk_in = 1'b0, aud_fs_in = 1'b0, aud_in_valid = 1'b0, slow = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, aud_in_data = 32'h0, prdata, rd, d;
  logic pready, pslverr, aud_in_ready, pk_valid, pk_ready, err;
  apt_word_t pk_word, g, exq[$];
  logic [31:0] smp[$];
  int mismatches = 0, n_compared = 0, chan;

  apt_audio_tx #(.N_WINDOW(16)) apt_audio_tx_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk_clk_in(lnk_clk_in),
    .aud_fs_in(aud_fs_in), .aud_in_valid(aud_in_valid), .aud_in_ready(aud_in_ready),
    .aud_in_data(aud_in_data), .pk_valid(pk_valid), .pk_ready(pk_ready), .pk_word(pk_word));
  apt_sink_model apt_sink_model_inst (.pclk(pclk), .presetn(presetn), .slow(slow),
    .pk_valid(pk_valid), .pk_ready(pk_ready), .pk_word(pk_word));

  initial forever #50 pclk = ~pclk;
  initial begin
    #137;
    forever #400 lnk_clk_in = ~lnk_clk_in;
  end
  initial begin
    #211;
    forever #800 aud_fs_in = ~aud_fs_in;
  end

  function automatic apt_word_t mk(apt_kind_t k, logic s, logic e, logic [31:0] v);
    mk = '{k, s, e, v};
  endfunction : mk

  task automatic chk(input string nm, input logic [35:0] e, input logic [35:0] v);
    n_compared++;
    if (v !== e) begin
      $display("[FAIL] %s expected %h seen %h", nm, e, v);
      mismatches++;
    end
  endtask : chk

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic fill(input int n);
    @(posedge pclk);
    aud_in_valid <= 1'b1;
    for (int i = 0; i < n; i++) begin
      smp.push_back($urandom);
      aud_in_data <= smp[$];
      @(posedge pclk);
      while (aud_in_ready !== 1'b1) @(posedge pclk);
    end
    aud_in_valid <= 1'b0;
  endtask : fill

  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : test_done

  initial begin
    #(8000 * 100);
    mismatches++;
    test_done();
  end

  initial begin
    void'($urandom(32'h9530));
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 12'h300, 0); chk("enable", 0, rd);
    chk("pk_valid", 0, pk_valid);
    apb(0, 12'h32c, 0); chk("n_value", 16, rd);
    apb(1, 12'h100, 0); chk("slverr", 1, err);
    apb(0, 12'h330, 0); chk("ext_read", 0, rd);
    chan = 1 << ($urandom % 3);
    apb(1, 12'h304, chan); apb(0, 12'h304, 0); chk("chan", chan, rd);
    for (int i = 0; i < 9; i++) begin
      d = $urandom;
      apb(1, 12'h330 + 12'(4 * i), d);
      exq.push_back(mk(APT_KIND_EXT, i == 0, i == 8, d));
    end
    for (int i = 0; i < 8; i++) begin
      d = $urandom;
      apb(1, 12'h308, d);
      exq.push_back(mk(APT_KIND_INFO, i == 0, i == 7, d));
    end
    fill(16);
    @(posedge pclk);
    chk("fifo_full", 0, aud_in_ready);
    repeat (200) @(posedge pclk);
    chk("idle", 0, apt_sink_model_inst.got.size());
    for (int p = 0; p < 16 / chan; p++) begin
      exq.push_back(mk(APT_KIND_SAMPLE, 1, 0, chan));
      for (int s = 0; s < chan; s++) exq.push_back(mk(APT_KIND_SAMPLE, 0, s == chan - 1,
        smp.pop_front()));
    end
    slow <= 1'b1;
    apb(1, 12'h300, 1);
    for (int i = 0; i < 5000 && apt_sink_model_inst.got.size() < exq.size(); i++)
      @(posedge pclk);
    chk("words", exq.size(), apt_sink_model_inst.got.size());
    foreach (exq[i]) begin
      g = apt_sink_model_inst.got[i];
      if (exq[i].sof && exq[i].kind == APT_KIND_SAMPLE) g.data[31:3] = '0;
      chk("word", exq[i], g);
    end
    apb(1, 12'h300, 0); fill(chan);
    repeat (100) @(posedge pclk);
    chk("stopped", exq.size(), apt_sink_model_inst.got.size());
    chk("pk_valid_off", 0, pk_valid);
    // Sample clock runs at half the link rate: 8 edges of 512 per 16-tick window
    apb(0, 12'h328, 0); chk("m_value", 32'd512 * 16 / 2, rd);
    test_done();
  end
endmodule : tb_top
